// *** include/css_pkg.sv ***
// constants, field layouts and carriers for the calendar schedule switch
// assumes a calendar clock that presents date and time as css_time_type
package css_pkg;

	// ==========================================================
	// table size and register map
	localparam int          NUM_INTERVALS = 32;
	localparam int          IDX_W         = 5;
	localparam logic [11:0] ON_BASE       = 12'h000;
	localparam logic [11:0] DATE_BASE     = 12'h080;
	localparam logic [11:0] OFF_BASE      = 12'h100;
	localparam logic [11:0] CTRL_ADDR     = 12'h180;
	localparam logic [11:0] STATUS_ADDR   = 12'h184;
	localparam logic [11:0] TABLE_SPAN    = 12'h080;

	// ==========================================================
	// field positions
	localparam int VALID_BIT  = 31;
	localparam int MODE_LSB   = 24;
	localparam int HOUR_LSB   = 16;
	localparam int MINUTE_LSB = 8;
	localparam int YEAR_LSB   = 24;
	localparam int MONTH_LSB  = 16;
	localparam int DAY_LSB    = 8;
	localparam int WDAY_LSB   = 0;
	localparam int CTRL_EN_BIT    = 0;
	localparam int CTRL_CLEAR_BIT = 1;
	localparam int STAT_OUT_BIT   = 0;
	localparam int STAT_IDX_LSB   = 8;
	localparam int STAT_HIT_BIT   = 16;

	// writable bits of each word
	localparam logic [31:0] ON_MASK   = 32'h871f3f00;
	localparam logic [31:0] DATE_MASK = 32'h7f0f1f07;
	localparam logic [31:0] OFF_MASK  = 32'h801f3f00;

	// ==========================================================
	// values after reset
	localparam logic [31:0] ENTRY_RESET = 32'h00000000;
	localparam logic        ENABLE_RESET = 1'b1;
	localparam logic        OUT_RESET    = 1'b0;

	// ==========================================================
	// time arithmetic
	localparam logic [10:0] MIN_PER_HOUR = 11'h03c;

	// ==========================================================
	// recurrence modes
	typedef enum logic [2:0] {
		CSS_YEARLY   = 3'h0,
		CSS_MONTHLY  = 3'h1,
		CSS_WEEKLY   = 3'h2,
		CSS_DAILY    = 3'h3,
		CSS_DEFINITE = 3'h4
	} css_mode_type;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic [6:0] year;
		logic [3:0] month;
		logic [4:0] day;
		logic [2:0] weekday;
		logic [4:0] hour;
		logic [5:0] minute;
	} css_time_type;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
		logic [3:0]  pstrb;
	} css_apb_req_type;

	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} css_apb_rsp_type;

endpackage

// *** hw/css_calendar_switch_block.sv ***
// calendar schedule switch: 32 on/off intervals drive one output
// assumes a register bus master on clk and a calendar clock that pulses
// time_tick whenever the presented date and time advance
//
// Summary of operation
// [RULE1] The table holds at most 32 intervals, each with a switch-on and a switch-off moment.
// [RULE2] The switch-on word of an interval holds the on moment and the recurrence mode.
// [RULE3] The switch-off word has no mode field and always uses the mode of its on word.
// [RULE4] The single output is 1 while an interval is active and 0 otherwise; the code holds its last value while no interval applies.
// [RULE5] The mode is one of yearly, monthly, weekly, daily or definite day.
// [RULE6] An interval repeats each year, month, week or day, or acts once on a definite date.
// [RULE7] With both moments set the output is on from the on moment until the off moment.
// [RULE8] Before the on moment the output holds its state, and at the off moment it goes off.
// [RULE9] Weekly and daily intervals may carry only one moment, which sets or clears at or after it.
// [RULE10] Software enters moments, same-day ones included, in ascending time order.
// [RULE11] Out-of-order entries are resolved so that the later entry wins.
// [RULE12] Every interval is re-evaluated on each calendar advance and the output updated then. A software clear in the same cycle drops the advance.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns

module css_calendar_switch_block (
	// clock, reset, freeze
	input  wire logic                     clk,
	input  wire logic                     nrst,
	input  wire logic                     ce,
	// register bus
	input  wire css_pkg::css_apb_req_type apb_req,
	output css_pkg::css_apb_rsp_type      apb_rsp,
	// calendar clock
	input  wire css_pkg::css_time_type    now,
	input  wire logic                     time_tick,
	// switch output
	output logic                          switch_out
);

	// ==========================================================
	// storage
	logic [31:0]               on_word   [css_pkg::NUM_INTERVALS]; // RULE1
	logic [31:0]               date_word [css_pkg::NUM_INTERVALS];
	logic [31:0]               off_word  [css_pkg::NUM_INTERVALS];
	logic                      enable;
	logic [css_pkg::IDX_W-1:0] last_idx;
	logic                      last_hit;
	logic [31:0]               rd_data;
	logic                      rd_ok;
	logic                      rd_err;

	// ==========================================================
	// helpers
	function automatic logic [10:0] tod(input logic [4:0] h, input logic [5:0] m);
		tod = 11'(h) * css_pkg::MIN_PER_HOUR + 11'(m);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] lane;
		lane = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		merge = ((old & ~lane) | (wd & lane)) & mask;
	endfunction

	function automatic logic [css_pkg::IDX_W-1:0] IDX_W_CAST(input int i);
		IDX_W_CAST = i[css_pkg::IDX_W-1:0];
	endfunction

	function automatic logic in_table(input logic [11:0] a, input logic [11:0] base);
		in_table = (a >= base) && (a < base + css_pkg::TABLE_SPAN) && (a[1:0] == 2'b00);
	endfunction

	// ==========================================================
	// bus decode
	logic                      setup;
	logic                      wr_go;
	logic [css_pkg::IDX_W-1:0] widx;
	logic                      hit_on;
	logic                      hit_date;
	logic                      hit_off;
	logic                      hit_ctrl;
	logic                      hit_stat;
	logic                      mapped;

	assign setup    = apb_req.psel && !apb_req.penable;
	assign widx     = apb_req.paddr[css_pkg::IDX_W+1:2];
	assign hit_on   = in_table(apb_req.paddr, css_pkg::ON_BASE);
	assign hit_date = in_table(apb_req.paddr, css_pkg::DATE_BASE);
	assign hit_off  = in_table(apb_req.paddr, css_pkg::OFF_BASE);
	assign hit_ctrl = apb_req.paddr == css_pkg::CTRL_ADDR;
	assign hit_stat = apb_req.paddr == css_pkg::STATUS_ADDR;
	assign mapped   = hit_on || hit_date || hit_off || hit_ctrl || hit_stat;
	assign wr_go    = ce && apb_req.psel && apb_req.penable && apb_req.pwrite && rd_ok
		&& !rd_err;

	// ready only once the read word was captured in the setup cycle
	assign apb_rsp.pready  = ce && apb_req.psel && apb_req.penable && rd_ok;
	assign apb_rsp.prdata  = rd_data;
	assign apb_rsp.pslverr = rd_err;

	// ==========================================================
	// read capture in the setup cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_data <= 32'h00000000;
			rd_ok   <= 1'b0;
			rd_err  <= 1'b0;
		end else if (ce) begin
			if (setup) begin
				rd_ok  <= 1'b1;
				rd_err <= !mapped;
				if (apb_req.pwrite || !mapped)
					rd_data <= 32'h00000000;
				else if (hit_on)
					rd_data <= on_word[widx];
				else if (hit_date)
					rd_data <= date_word[widx];
				else if (hit_off)
					rd_data <= off_word[widx];
				else if (hit_ctrl)
					rd_data <= 32'(enable) << css_pkg::CTRL_EN_BIT;
				else
					rd_data <= (32'(switch_out) << css_pkg::STAT_OUT_BIT)
						| (32'(last_idx) << css_pkg::STAT_IDX_LSB)
						| (32'(last_hit) << css_pkg::STAT_HIT_BIT);
			end else if (!apb_req.psel || apb_rsp.pready) begin
				rd_ok  <= 1'b0;
				rd_err <= 1'b0;
			end
		end
	end

	// ==========================================================
	// interval table writes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < css_pkg::NUM_INTERVALS; i++) begin
				on_word[i]   <= css_pkg::ENTRY_RESET;
				date_word[i] <= css_pkg::ENTRY_RESET;
				off_word[i]  <= css_pkg::ENTRY_RESET;
			end
		end else if (wr_go) begin
			// the on word carries the mode; the off word mask has no mode field
			if (hit_on)
				on_word[widx] <= merge(on_word[widx], apb_req.pwdata, apb_req.pstrb,
					css_pkg::ON_MASK); // RULE2
			if (hit_date)
				date_word[widx] <= merge(date_word[widx], apb_req.pwdata, apb_req.pstrb,
					css_pkg::DATE_MASK);
			if (hit_off)
				off_word[widx] <= merge(off_word[widx], apb_req.pwdata, apb_req.pstrb,
					css_pkg::OFF_MASK); // RULE3
		end
	end

	// ==========================================================
	// control
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			enable <= css_pkg::ENABLE_RESET;
		else if (wr_go && hit_ctrl && apb_req.pstrb[0])
			enable <= apb_req.pwdata[css_pkg::CTRL_EN_BIT];
	end

	// ==========================================================
	// evaluation, ascending index so a later entry overrides an earlier one
	logic                      next_out;
	logic [css_pkg::IDX_W-1:0] next_idx;
	logic                      next_hit;

	always_comb begin
		css_pkg::css_mode_type mode;
		logic                  on_v;
		logic                  off_v;
		logic                  period;
		logic                  single_ok;
		logic [10:0]           t_now;
		logic [10:0]           t_on;
		logic [10:0]           t_off;
		mode      = css_pkg::CSS_YEARLY;
		on_v      = 1'b0;
		off_v     = 1'b0;
		period    = 1'b0;
		single_ok = 1'b0;
		t_on      = 11'h000;
		t_off     = 11'h000;
		t_now     = tod(now.hour, now.minute);
		next_out  = switch_out;
		next_idx  = last_idx;
		next_hit  = last_hit;
		// RULE10
		for (int i = 0; i < css_pkg::NUM_INTERVALS; i++) begin
			mode  = css_pkg::css_mode_type'(on_word[i][css_pkg::MODE_LSB +: 3]); // RULE3
			on_v  = on_word[i][css_pkg::VALID_BIT];
			off_v = off_word[i][css_pkg::VALID_BIT];
			t_on  = tod(on_word[i][css_pkg::HOUR_LSB +: 5], on_word[i][css_pkg::MINUTE_LSB +: 6]);
			t_off = tod(off_word[i][css_pkg::HOUR_LSB +: 5],
				off_word[i][css_pkg::MINUTE_LSB +: 6]);
			// which calendar days the interval applies to
			case (mode) // RULE5
				css_pkg::CSS_YEARLY: begin // RULE6
					period = now.month == date_word[i][css_pkg::MONTH_LSB +: 4]
						&& now.day == date_word[i][css_pkg::DAY_LSB +: 5];
				end
				css_pkg::CSS_MONTHLY: begin // RULE6
					period = now.day == date_word[i][css_pkg::DAY_LSB +: 5];
				end
				css_pkg::CSS_WEEKLY: begin // RULE6
					period = now.weekday == date_word[i][css_pkg::WDAY_LSB +: 3];
				end
				css_pkg::CSS_DAILY: begin // RULE6
					period = 1'b1;
				end
				css_pkg::CSS_DEFINITE: begin // RULE6
					period = now.year == date_word[i][css_pkg::YEAR_LSB +: 7]
						&& now.month == date_word[i][css_pkg::MONTH_LSB +: 4]
						&& now.day == date_word[i][css_pkg::DAY_LSB +: 5];
				end
				default: begin
					period = 1'b0;
				end
			endcase
			single_ok = mode == css_pkg::CSS_WEEKLY || mode == css_pkg::CSS_DAILY;
			if (period) begin
				if (on_v && off_v) begin
					if (t_now >= t_on && t_now < t_off) begin
						next_out = 1'b1; // RULE7
						next_idx = IDX_W_CAST(i);
						next_hit = 1'b1; // RULE11
					end else if (t_now >= t_off) begin
						next_out = 1'b0; // RULE8
						next_idx = IDX_W_CAST(i);
						next_hit = 1'b1; // RULE11
					end
				end else if (single_ok && on_v && t_now >= t_on) begin
					next_out = 1'b1; // RULE9
					next_idx = IDX_W_CAST(i);
					next_hit = 1'b1;
				end else if (single_ok && off_v && t_now >= t_off) begin
					next_out = 1'b0; // RULE9
					next_idx = IDX_W_CAST(i);
					next_hit = 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// output register, updated once per calendar advance
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			switch_out <= css_pkg::OUT_RESET;
			last_idx   <= '0;
			last_hit   <= 1'b0;
		end else if (ce) begin
			if (wr_go && hit_ctrl && apb_req.pstrb[0]
					&& apb_req.pwdata[css_pkg::CTRL_CLEAR_BIT]) begin
				// software clear; an evaluation in the same cycle is dropped on purpose
				switch_out <= css_pkg::OUT_RESET;
				last_hit   <= 1'b0;
			end else if (time_tick && enable) begin
				switch_out <= next_out; // RULE4 RULE12
				last_idx   <= next_idx;
				last_hit   <= next_hit;
			end
		end
	end

endmodule // css_calendar_switch_block

// *** verif/css_props.sv ***
// port checker for the calendar schedule switch
// assumes it is bound to every css_calendar_switch_block instance
`timescale 1ns/1ns

module css_props (
	// clock and reset
	input wire logic                     clk,
	input wire logic                     nrst,
	input wire logic                     ce,
	// register bus
	input wire css_pkg::css_apb_req_type apb_req,
	input wire css_pkg::css_apb_rsp_type apb_rsp,
	// calendar and output
	input wire css_pkg::css_time_type    now,
	input wire logic                     time_tick,
	input wire logic                     switch_out
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	logic done;
	assign done = apb_req.psel && apb_req.penable && apb_rsp.pready;

	// ==========================================================
	// schedule output
	out_hold_a: assert property (!(ce && time_tick) && !(done && apb_req.pwrite)
		|=> $stable(switch_out)) else $error("output moved with no tick");
	rise_cause_a: assert property ($rose(switch_out) |-> $past(ce && time_tick))
		else $error("output rose without a calendar advance");
	clear_out_a: assert property (done && apb_req.pwrite && apb_req.pstrb[0]
		&& apb_req.paddr == css_pkg::CTRL_ADDR && apb_req.pwdata[1] |=> !switch_out)
		else $error("clear did not drop the output");
	status_out_a: assert property (done && !apb_req.pwrite && $stable(switch_out)
		&& apb_req.paddr == css_pkg::STATUS_ADDR |-> apb_rsp.prdata[0] == switch_out)
		else $error("status does not mirror the output");

	// ==========================================================
	// register bus
	zero_wait_a: assert property (ce && apb_req.psel && !apb_req.penable
		##1 ce && apb_req.psel && apb_req.penable |-> apb_rsp.pready)
		else $error("access phase not answered at once");
	ready_qual_a: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable && ce)
		else $error("ready outside an access phase");
	unmapped_err_a: assert property (done && apb_req.paddr > css_pkg::STATUS_ADDR
		|-> apb_rsp.pslverr) else $error("unmapped address not refused");
	err_data_a: assert property (done && apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0)
		else $error("refused access returned data");
endmodule // css_props

bind css_calendar_switch_block css_props u_props (.clk(clk), .nrst(nrst), .ce(ce),
	.apb_req(apb_req), .apb_rsp(apb_rsp), .now(now), .time_tick(time_tick),
	.switch_out(switch_out));

// *** verif/css_cal_model.sv ***
// calendar clock stand-in: presents a date and time and strobes each advance
// assumes the bench asks for each new value with set_req for one cycle
`timescale 1ns/1ns

module css_cal_model (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  nrst,
	// request from the bench
	input  wire logic                  set_req,
	input  wire css_pkg::css_time_type set_val,
	// calendar link
	output css_pkg::css_time_type      now,
	output logic                       time_tick
);
	// the value only moves together with the strobe, as a real calendar does
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			now <= '0;
			time_tick <= 1'b0;
		end else begin
			time_tick <= set_req;
			if (set_req) begin
				now <= set_val;
			end
		end
	end
endmodule // css_cal_model

// *** verif/css_testbench.sv ***
// self-checking bench for the calendar schedule switch
// assumes css_props is bound by its own file and the calendar model answers in one cycle
`timescale 1ns/1ns

module testbench;
	logic                     clk;
	logic                     nrst;
	logic                     ce;
	logic                     tgo;
	logic                     tick;
	logic                     sw;
	logic                     er;
	logic [31:0]              rd;
	logic [4:0]               alt_hit;
	css_pkg::css_apb_req_type req;
	css_pkg::css_apb_rsp_type rsp;
	css_pkg::css_time_type    now;
	css_pkg::css_time_type    tval;
	int                       err_total;
	int                       total_checks;
	localparam logic [18:0]   D0 = {7'h02, 4'h5, 5'h01, 3'h3};
	localparam logic [18:0]   DA = {7'h03, 4'h6, 5'h01, 3'h3};

	css_calendar_switch_block u_dut (.clk(clk), .nrst(nrst), .ce(ce), .apb_req(req),
		.apb_rsp(rsp), .now(now), .time_tick(tick), .switch_out(sw));
	css_cal_model u_cal (.clk(clk), .nrst(nrst), .set_req(tgo), .set_val(tval),
		.now(now), .time_tick(tick));

	always #25 clk = ~clk;

	task automatic end_sim;
		if (err_total == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (e !== g) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// holds the request until ready is seen, then takes the answer at that edge
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, wr, a, d, 4'hf};
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	function automatic logic [31:0] onw(input logic [2:0] md, input logic [4:0] h,
		input logic [5:0] mi);
		return {1'b1, 4'h0, md, 3'h0, h, 2'h0, mi, 8'h0};
	endfunction

	task automatic iv(input logic [4:0] i, input logic [31:0] on, input logic [18:0] dt,
		input logic [4:0] h, input logic [5:0] mi, input logic ov);
		bus(1'b1, css_pkg::ON_BASE + {5'h0, i, 2'h0}, on);
		bus(1'b1, css_pkg::DATE_BASE + {5'h0, i, 2'h0},
			{1'b0, dt[18:12], 4'h0, dt[11:8], 3'h0, dt[7:3], 5'h0, dt[2:0]});
		bus(1'b1, css_pkg::OFF_BASE + {5'h0, i, 2'h0}, {ov, 10'h0, h, 2'h0, mi, 8'h0});
		bus(1'b1, css_pkg::CTRL_ADDR, 32'h3);
	endtask

	task automatic tk(input logic [18:0] dt, input logic [4:0] h, input logic [5:0] mi,
		input logic e);
		@(posedge clk);
		tval <= {dt, h, mi};
		tgo <= 1'b1;
		@(posedge clk);
		tgo <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("switch_out", {31'h0, e}, {31'h0, sw});
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		end_sim();
	end

	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		ce = 1'b1;
		tgo = 1'b0;
		req = '0;
		tval = '0;
		err_total = 0;
		total_checks = 0;
		alt_hit = 5'b01110;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		bus(1'b0, css_pkg::CTRL_ADDR, 32'h0);
		chk("ctrl", 32'h1, rd);
		bus(1'b0, css_pkg::STATUS_ADDR, 32'h0);
		chk("status", 32'h0, rd);
		bus(1'b1, css_pkg::ON_BASE, 32'hffffffff);
		bus(1'b0, css_pkg::ON_BASE, 32'h0);
		chk("on word", 32'h871f3f00, rd);
		bus(1'b1, css_pkg::OFF_BASE, 32'hffffffff);
		bus(1'b0, css_pkg::OFF_BASE, 32'h0);
		chk("off word", 32'h801f3f00, rd);
		bus(1'b0, 12'h188, 32'h0);
		chk("unmapped", 32'h1, {31'h0, er});
		// interval moments entered in ascending order
		iv(5'h00, onw(3'h3, 5'h08, 6'h00), D0, 5'h11, 6'h00, 1'b1);
		tk(D0, 5'h07, 6'h3b, 1'b0);
		tk(D0, 5'h08, 6'h00, 1'b1);
		tk(D0, 5'h10, 6'h3b, 1'b1);
		tk(D0, 5'h11, 6'h00, 1'b0);
		// a frozen block must ignore an advance that would switch it on
		@(posedge clk);
		ce <= 1'b0;
		tk(D0, 5'h08, 6'h00, 1'b0);
		@(posedge clk);
		ce <= 1'b1;
		for (int m = 0; m < 5; m++) begin
			iv(5'h00, onw(3'(m), 5'h08, 6'h00), D0, 5'h11, 6'h00, 1'b1);
			tk(D0, 5'h0a, 6'h00, 1'b1);
			bus(1'b1, css_pkg::CTRL_ADDR, 32'h3);
			tk(DA, 5'h0a, 6'h00, alt_hit[m]);
		end
		// later entry wins when the table is out of order
		iv(5'h00, onw(3'h0, 5'h0a, 6'h00), DA, 5'h0b, 6'h00, 1'b1);
		iv(5'h01, onw(3'h0, 5'h08, 6'h00), DA, 5'h09, 6'h00, 1'b1);
		tk(DA, 5'h0a, 6'h1e, 1'b0);
		bus(1'b1, css_pkg::ON_BASE, 32'h0);
		bus(1'b1, css_pkg::ON_BASE + 12'h004, 32'h0);
		iv(5'h1f, onw(3'h2, 5'h09, 6'h00), D0, 5'h00, 6'h00, 1'b0);
		tk(D0, 5'h08, 6'h3b, 1'b0);
		tk(D0, 5'h09, 6'h00, 1'b1);
		bus(1'b1, css_pkg::ON_BASE + 12'h07c, onw(3'h2, 5'h09, 6'h00) & 32'h7fffffff);
		bus(1'b1, css_pkg::OFF_BASE + 12'h07c, {11'h401, 5'h0c, 16'h0});
		tk(D0, 5'h0b, 6'h3b, 1'b1);
		tk(D0, 5'h0c, 6'h00, 1'b0);
		iv(5'h1f, onw(3'h0, 5'h09, 6'h00), D0, 5'h00, 6'h00, 1'b0);
		tk(D0, 5'h0a, 6'h00, 1'b0);
		end_sim();
	end
endmodule // testbench
